/* File: sram_write_command_byte_mask_test.sv */
// Self-checking bench for the SRAM write path, with a shadow copy of the array.
// Assumes the controller model drives the command lines and the bench reads back words.
`timescale 1ns/10ps
module sram_write_command_byte_mask_test;
  localparam int W  = sramw_pkg::DATA_W;
  localparam int AW = sramw_pkg::ADDR_W;
  logic                          clk, resetn, store_stall, in_ready, write_active, rd_go, rd_v;
  logic                          k_rise, k_n_rise, write_sel_n;
  logic [AW-1:0]                 addr, a;
  logic [sramw_pkg::LANES-1:0]   lane_en_n;
  logic [W-1:0]                  data_in, rd_data;
  logic [AW:0]                   rd_index;
  logic [W-1:0]                  shadow [0:sramw_pkg::WORDS-1];
  logic [W-1:0]                  exp_q [$];
  int                            err_total, total_checks;

  sramw_ctl_model ctl (.clk(clk), .k_rise(k_rise), .k_n_rise(k_n_rise),
    .write_sel_n(write_sel_n), .addr(addr), .byte_lane_write_enable_n(lane_en_n),
    .data_in(data_in));
  sramw_write_path dut (.clk(clk), .resetn(resetn), .k_rise(k_rise), .k_n_rise(k_n_rise),
    .write_sel_n(write_sel_n), .addr(addr), .byte_lane_write_enable_n(lane_en_n),
    .data_in(data_in), .in_ready(in_ready), .write_active(write_active),
    .store_stall(store_stall), .rd_index(rd_index), .rd_data(rd_data));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check_word(input logic [W-1:0] g, x);
    total_checks++;
    if (g !== x)
    begin
      err_total++;
      $display("wrong value at %0t: word %h expected %h", $time, g, x);
    end
  endtask

  task automatic check_flag(input logic g, x);
    total_checks++;
    if (g !== x)
    begin
      err_total++;
      $display("wrong value at %0t: flag %b expected %b", $time, g, x);
    end
  endtask

  // Only lanes written with a low enable change the shadow copy.
  task automatic note(input logic [AW:0] i, input logic [3:0] e, input logic [W-1:0] d);
    for (int l = 0; l < sramw_pkg::LANES; l++)
      if (!e[l])
        shadow[i][9*l +: 9] = d[9*l +: 9];
  endtask

  task automatic wr(input logic [AW-1:0] wa, input logic [3:0] e0, e1);
    logic [W-1:0] d0, d1;
    d0 = W'({$urandom, $urandom});
    d1 = W'({$urandom, $urandom});
    note({wa, 1'b0}, e0, d0);
    note({wa, 1'b1}, e1, d1);
    fork
      ctl.write_cycle(wa, e0, e1, d0, d1);
      begin
        repeat (2) @(negedge clk);
        check_flag(write_active, 1'b1);
      end
    join
  endtask

  task automatic rd(input logic [AW:0] i);
    @(negedge clk);
    rd_index = i;
    rd_go = 1'b1;
    exp_q.push_back(shadow[i]);
    @(negedge clk);
    rd_go = 1'b0;
  endtask

  always @(posedge clk)
    rd_v <= rd_go;
  always @(negedge clk)
    if (rd_v === 1'b1)
      check_word(rd_data, exp_q.pop_front());

  initial
  begin
    void'($urandom(32'hE173B1E4));
    ctl.rest();
    {resetn, store_stall, rd_go, rd_index} = '0;
    err_total = 0;
    total_checks = 0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    check_flag(write_active, 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      a = AW'($urandom);
      wr(a, 4'h0, 4'h0);
      wr(a, i[3:0], ~i[3:0]);
      check_flag(write_active, 1'b0);
      rd({a, 1'b0});
      rd({a, 1'b1});
    end
    ctl.stray_select();
    check_flag(write_active, 1'b0);
    store_stall = 1'b1;
    a = AW'($urandom);
    wr(a, 4'h0, 4'h0);
    check_flag(in_ready, 1'b0);
    store_stall = 1'b0;
    repeat (4) @(negedge clk);
    check_flag(in_ready, 1'b1);
    rd({a, 1'b0});
    rd({a, 1'b1});
    repeat (3) @(negedge clk);
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end
endmodule // sram_write_command_byte_mask_test

/* File: sramw_ctl_model.sv */
// Behavioural memory controller that drives the write side of the SRAM.
// Assumes the bench calls rest, write_cycle and stray_select from its main sequence.
`timescale 1ns/10ps
module sramw_ctl_model
(
  input  wire logic                         clk,
  output      logic                         k_rise,
  output      logic                         k_n_rise,
  output      logic                         write_sel_n,
  output      logic [sramw_pkg::ADDR_W-1:0] addr,
  output      logic [sramw_pkg::LANES-1:0]  byte_lane_write_enable_n,
  output      logic [sramw_pkg::DATA_W-1:0] data_in
);
  // Idle levels: no edge pulses, select and every lane enable high.
  task automatic rest();
    {k_rise, k_n_rise, write_sel_n} = 3'h1;
    addr = '0;
    byte_lane_write_enable_n = '1;
    data_in = '0;
  endtask

  // The pulses, the select and the beat lines change together after a falling edge.
  task automatic step(input logic [2:0] c, input logic [3:0] e, input logic [35:0] d);
    @(negedge clk);
    {k_rise, k_n_rise, write_sel_n} = c;
    byte_lane_write_enable_n = e;
    data_in = d;
  endtask

  // Between beats the lines carry the inverse of the last value, so stale data never passes.
  task automatic write_cycle(input logic [7:0] a, input logic [3:0] e0, e1,
                             input logic [35:0] d0, d1);
    step(3'h4, e0, d0);
    addr = a;
    step(3'h1, ~e0, ~d0);
    addr = ~a;
    step(3'h3, e1, d1);
    step(3'h1, ~e1, ~d1);
    step(3'h4, 4'h0, ~d1);
    addr = a;
    step(3'h1, 4'hF, d1);
  endtask

  task automatic stray_select();
    step(3'h2, 4'h0, 36'h0);
    step(3'h1, 4'hF, 36'hF);
  endtask
endmodule // sramw_ctl_model

/* File: sramw_fifo2.sv */
// Two-entry buffer for captured write beats.
// Assumes the writer honours in_ready and the reader may stall at will.
`timescale 1ns/10ps
module sramw_fifo2
(
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     in_valid,
  output      logic                     in_ready,
  input  wire sramw_pkg::sramw_beat_type in_data,
  output      logic                     out_valid,
  input  wire logic                     out_ready,
  output      sramw_pkg::sramw_beat_type out_data
);

  sramw_pkg::sramw_beat_type slot_reg [sramw_pkg::BUF_DEPTH];
  sramw_pkg::sramw_beat_type slot_next [sramw_pkg::BUF_DEPTH];
  logic [1:0]               count_reg;
  logic [1:0]               count_next;
  logic                     push;
  logic                     pop;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = slot_reg[0];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    slot_next[0] = slot_reg[0];
    slot_next[1] = slot_reg[1];
    count_next   = count_reg;
    // Slot 0 is always the head, so a pop shifts slot 1 down.
    if (pop)
    begin
      slot_next[0] = slot_reg[1];
    end
    if (push)
    begin
      if (count_reg == 2'h0 || (count_reg == 2'h1 && pop))
      begin
        slot_next[0] = in_data;
      end
      else
      begin
        slot_next[1] = in_data;
      end
    end
    if (push && !pop)
    begin
      count_next = count_reg + 2'h1;
    end
    else if (pop && !push)
    begin
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      count_reg <= 2'h0;
    end
    else
    begin
      count_reg <= count_next;
    end
    slot_reg[0] <= slot_next[0];
    slot_reg[1] <= slot_next[1];
  end

  // A stalled head must neither move nor change, or a beat would be lost.
  a_head_held : assert property (@(posedge clk) disable iff (!resetn)
    (out_valid && !out_ready) |=> (out_valid && out_data == $past(out_data)))
    else $error("buffer head moved while the reader stalled");

endmodule // sramw_fifo2

/* File: sramw_pkg.sv */
// Shared constants and carrier types of the synchronous SRAM write path.
// Assumes a single 200 MHz system clock with the input clock pair seen as edge pulses.
package sramw_pkg;

  // Organisation of the part: 9, 18 or 36 bits per word.
  localparam int ORG_WIDTH = 36;
  localparam int LANE_W    = 9;
  localparam int LANES     = (ORG_WIDTH == 9) ? 1 : ((ORG_WIDTH == 18) ? 2 : 4);
  localparam int DATA_W    = LANES * LANE_W;
  localparam int ADDR_W    = 8;
  localparam int BEATS     = 2;
  localparam int WORDS     = (1 << ADDR_W) * BEATS;
  localparam int BUF_DEPTH = 2;

  localparam logic [LANES-1:0] LANES_OFF_N = '1;
  localparam logic             BEAT_FIRST  = 1'b0;
  localparam logic             BEAT_SECOND = 1'b1;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b001,
    ST_SECOND = 3'b010,
    ST_IGNORE = 3'b100
  } sramw_state_type;

  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic              beat;
    logic [LANES-1:0]  lane_en_n;
    logic [DATA_W-1:0] data;
  } sramw_beat_type;

endpackage

/* File: sramw_write_path.sv */
// Write command and byte-write qualification of a synchronous SRAM, with its array.
// Assumes k_rise and k_n_rise are one-cycle pulses marking rising edges of the clock pair.
//
// What this block does
// R01: Low write select captures address, starts write.
// R02: Write select sampled only on primary edge.
// R03: Select on the next primary edge ignored.
// R04: Byte lane stored only when enable low.
// R05: Enables sampled on both edges of cycle.
// R06: Enable count follows 9, 18, 36 organisation.
// R07: Address on primary edge, data on both.
// R08: Disabled lane leaves stored byte unchanged.
`timescale 1ns/10ps
module sramw_write_path
(
  input  wire logic                                  clk,
  input  wire logic                                  resetn,
  input  wire logic                                  k_rise,
  input  wire logic                                  k_n_rise,
  input  wire logic                                  write_sel_n,
  input  wire logic [sramw_pkg::ADDR_W-1:0]          addr,
  input  wire logic [sramw_pkg::LANES-1:0]           byte_lane_write_enable_n,
  input  wire logic [sramw_pkg::DATA_W-1:0]          data_in,
  output      logic                                  in_ready,
  output      logic                                  write_active,
  input  wire logic                                  store_stall,
  input  wire logic [sramw_pkg::ADDR_W:0]            rd_index,
  output      logic [sramw_pkg::DATA_W-1:0]          rd_data
);

  sramw_pkg::sramw_state_type state_reg;
  sramw_pkg::sramw_state_type state_next;
  logic [sramw_pkg::ADDR_W-1:0] addr_reg;
  logic [sramw_pkg::ADDR_W-1:0] addr_next;
  logic                         accept;
  logic                         push_valid;
  sramw_pkg::sramw_beat_type    push_beat;
  logic                         pop_valid;
  logic                         pop_ready;
  sramw_pkg::sramw_beat_type    pop_beat;
  logic                         pop_fire;
  logic [sramw_pkg::ADDR_W:0]   pop_index;
  logic [sramw_pkg::DATA_W-1:0] mem_array [sramw_pkg::WORDS];
  logic [sramw_pkg::DATA_W-1:0] cur_word;
  logic [sramw_pkg::DATA_W-1:0] rd_data_reg;

  // Only the primary edge looks at the select, and only when no cycle is open.
  assign accept = (state_reg == sramw_pkg::ST_IDLE) && k_rise && !write_sel_n; // R01 R02

  always_comb
  begin
    state_next = state_reg;
    addr_next  = addr_reg;
    case (state_reg)
      sramw_pkg::ST_IDLE:
      begin
        if (accept)
        begin
          state_next = sramw_pkg::ST_SECOND;
          addr_next  = addr; // R01 R07
        end
      end
      sramw_pkg::ST_SECOND:
      begin
        if (k_n_rise)
        begin
          state_next = sramw_pkg::ST_IGNORE;
        end
      end
      sramw_pkg::ST_IGNORE:
      begin
        // The select on this primary edge is dropped whatever its level.
        if (k_rise)
        begin
          state_next = sramw_pkg::ST_IDLE; // R03
        end
      end
      default:
      begin
        state_next = sramw_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= sramw_pkg::ST_IDLE;
      addr_reg  <= '0;
    end
    else
    begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
    end
  end

  assign write_active = (state_reg != sramw_pkg::ST_IDLE);

  // The lane enables and data travel with each beat, one beat per edge of the pair.
  always_comb
  begin
    push_valid          = 1'b0;
    push_beat.addr      = addr_reg;
    push_beat.beat      = sramw_pkg::BEAT_FIRST;
    push_beat.lane_en_n = byte_lane_write_enable_n; // R05 R06
    push_beat.data      = data_in;                  // R07
    if (accept)
    begin
      push_valid     = 1'b1;
      push_beat.addr = addr;
    end
    else if (state_reg == sramw_pkg::ST_SECOND && k_n_rise)
    begin
      push_valid     = 1'b1; // R05
      push_beat.beat = sramw_pkg::BEAT_SECOND;
    end
  end

  // The buffer absorbs a short stall of the array; a longer one shows as in_ready low.
  sramw_fifo2 u_beat_buf
  (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (push_valid),
    .in_ready  (in_ready),
    .in_data   (push_beat),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_beat)
  );

  assign pop_ready = !store_stall;
  assign pop_fire  = pop_valid && pop_ready;
  assign pop_index = {pop_beat.addr, pop_beat.beat};
  assign cur_word  = mem_array[pop_index];

  // The array has no reset; a word reads unknown until a beat has written it.
  always_ff @(posedge clk)
  begin
    if (pop_fire)
    begin
      for (int l = 0; l < sramw_pkg::LANES; l++)
      begin
        if (!pop_beat.lane_en_n[l])
        begin
          mem_array[pop_index][l*sramw_pkg::LANE_W +: sramw_pkg::LANE_W] <=
            pop_beat.data[l*sramw_pkg::LANE_W +: sramw_pkg::LANE_W]; // R04 R08
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rd_data_reg <= '0;
    end
    else
    begin
      rd_data_reg <= mem_array[rd_index];
    end
  end

  assign rd_data = rd_data_reg;

  a_sel_primary_only : assert property (@(posedge clk) disable iff (!resetn) // R02
    (state_reg == sramw_pkg::ST_IDLE && !k_rise) |=> (state_reg == sramw_pkg::ST_IDLE))
    else $error("write started without a primary edge");

  a_active_after_cmd : assert property (@(posedge clk) disable iff (!resetn) // R01
    accept |=> write_active)
    else $error("accepted write not shown as active");

  a_stray_no_beat : assert property (@(posedge clk) disable iff (!resetn) // R02
    (state_reg == sramw_pkg::ST_IDLE && !k_rise) |-> !push_valid)
    else $error("beat taken without an accepted command");

  a_ignore_ends : assert property (@(posedge clk) disable iff (!resetn) // R03
    (state_reg == sramw_pkg::ST_IGNORE && k_rise) |=> !write_active)
    else $error("write cycle not closed on the ignored primary edge");

  a_cmd_capture : assert property (@(posedge clk) disable iff (!resetn) // R01
    (state_reg == sramw_pkg::ST_IDLE && k_rise && !write_sel_n)
      |=> (state_reg == sramw_pkg::ST_SECOND && addr_reg == $past(addr)))
    else $error("write command not captured");

  a_next_ignored : assert property (@(posedge clk) disable iff (!resetn) // R03
    (state_reg == sramw_pkg::ST_IGNORE && k_rise && !write_sel_n)
      |-> !push_valid
      ##1 (state_reg == sramw_pkg::ST_IDLE && addr_reg == $past(addr_reg)))
    else $error("select on following primary edge was taken");

  a_first_beat : assert property (@(posedge clk) disable iff (!resetn) // R05
    accept |-> (push_valid && push_beat.beat == sramw_pkg::BEAT_FIRST
      && push_beat.lane_en_n == byte_lane_write_enable_n))
    else $error("first beat not sampled on primary edge");

  a_second_beat : assert property (@(posedge clk) disable iff (!resetn) // R07
    (state_reg == sramw_pkg::ST_SECOND && k_n_rise) |-> (push_valid
      && push_beat.beat == sramw_pkg::BEAT_SECOND && push_beat.addr == addr_reg
      && push_beat.data == data_in))
    else $error("second beat not sampled on complementary edge");

  // The lane checks watch lane 0 only; every lane runs through the same loop body.
  a_lane_written : assert property (@(posedge clk) disable iff (!resetn) // R04
    (pop_fire && !pop_beat.lane_en_n[0])
      |=> (mem_array[$past(pop_index)][sramw_pkg::LANE_W-1:0]
        == $past(pop_beat.data[sramw_pkg::LANE_W-1:0])))
    else $error("enabled lane not stored");

  a_lane_kept : assert property (@(posedge clk) disable iff (!resetn) // R08
    (pop_fire && pop_beat.lane_en_n[0])
      |=> (mem_array[$past(pop_index)][sramw_pkg::LANE_W-1:0]
        == $past(cur_word[sramw_pkg::LANE_W-1:0])))
    else $error("disabled lane was modified");

  a_mask_covers_word : assert property (@(posedge clk) disable iff (!resetn) // R06
    (pop_fire && pop_beat.lane_en_n == sramw_pkg::LANES_OFF_N)
      |=> (mem_array[$past(pop_index)] == $past(cur_word)))
    else $error("beat with every lane off changed the word");

endmodule // sramw_write_path
